/* File: rtl/rsp_serial_port.sv */
`timescale 1ns/10ps
// Two-wire serial target port in front of the clock control register array.
module rsp_serial_port #(
  parameter logic [6:0] TARGET_ID    = 7'h2a,  // Arbitrary value, set per product.
  parameter int         PWRUP_CYCLES = rsp_pkg::PWRUP_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic alarm_event,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      alarm_flag
);

  // Synchronised lines and bus events.
  logic scl_s;       // Clock line after two flops.
  logic sda_s;       // Data line after two flops.
  logic scl_rise;    // One-cycle pulse on a rising clock.
  logic scl_fall;    // One-cycle pulse on a falling clock.
  logic start_det;   // Start or repeated start seen.
  logic stop_det;    // Stop seen.
  logic bus_ev;      // Either start or stop, which outrank bit events.

  // Power-up sequencing.
  logic [15:0] pwr_cnt_q;  // Cycles spent in the power-up sequence.
  logic        busy_q;     // High until the power-up sequence ends.

  // Protocol state.
  rsp_pkg::rsp_state_e state_q;  // Sequencer state.
  logic [7:0] rx_q;              // Receive shift register.
  logic [7:0] tx_q;              // Remaining bits of the byte being sent.
  logic [2:0] bit_cnt_q;         // Bits taken or sent in the current byte.
  logic       full_q;            // A whole byte has been received.
  logic       dir_q;             // Direction bit of the last matching identifier.
  logic       more_q;            // Controller acknowledged the last sent byte.
  logic [7:0] ptr_q;             // Internal address counter.
  logic       sda_oe_q;          // Data line pulled low while high.
  logic       sda_out_q;         // Level driven when enabled; always low.

  // Register array port.
  logic       wr_en;    // Write strobe for one data byte.
  logic       load;     // Fetch the next byte to send.
  logic [7:0] rd_data;  // Byte addressed by the pointer.

  // Advance the pointer, wrapping after the last implemented address.
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p >= rsp_pkg::REG_LAST) ? rsp_pkg::REG_RESET : 8'(p + 8'h01);
  endfunction

  rsp_line_sync u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  assign bus_ev = start_det | stop_det;

  // The power-up sequence runs for a fixed count after reset release.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_cnt_q <= 16'h0000;
      busy_q    <= 1'b1;
    end
    else if (busy_q)
    begin
      if (pwr_cnt_q == 16'(PWRUP_CYCLES - 1))
        busy_q <= 1'b0;
      else
        pwr_cnt_q <= 16'(pwr_cnt_q + 16'h0001);
    end
  end

  // One data byte is written as its acknowledge is driven; only one per frame.
  assign wr_en = (state_q == rsp_pkg::RSP_WDATA) && scl_fall && full_q && !bus_ev;

  // A byte is fetched after a read identifier or after each acknowledged byte.
  assign load = scl_fall && !bus_ev &&
                ((state_q == rsp_pkg::RSP_ACK_ID && dir_q) ||
                 (state_q == rsp_pkg::RSP_TX_ACK && more_q));

  rsp_reg_array u_regs (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr_en      (wr_en),
    .wr_addr    (ptr_q),
    .wr_data    (rx_q),
    .rd_en      (load),
    .rd_addr    (ptr_q),
    .rd_data    (rd_data),
    .alarm_set  (alarm_event),
    .alarm_flag (alarm_flag)
  );

  // The sequencer. Stop and start take priority over any bit event, so a
  // controller may abort at any point; clock edges are only ever taken from
  // the synchronised line, which costs two cycles of latency but keeps the
  // port safe against a clock that arrives from another domain.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q   <= rsp_pkg::RSP_IDLE;
      rx_q      <= rsp_pkg::REG_RESET;
      tx_q      <= rsp_pkg::REG_RESET;
      bit_cnt_q <= 3'h0;
      full_q    <= 1'b0;
      dir_q     <= 1'b0;
      more_q    <= 1'b0;
      ptr_q     <= rsp_pkg::REG_RESET;
      sda_oe_q  <= 1'b0;
    end
    else if (stop_det)
    begin
      // Back to standby and release the line.
      state_q  <= rsp_pkg::RSP_IDLE;
      sda_oe_q <= 1'b0;
      full_q   <= 1'b0;
    end
    else if (start_det)
    begin
      // A start during power-up is simply not seen.
      if (!busy_q)
      begin
        state_q   <= rsp_pkg::RSP_ID;
        bit_cnt_q <= 3'h0;
        full_q    <= 1'b0;
        sda_oe_q  <= 1'b0;
      end
    end
    else
    begin
      unique case (state_q)
        // Standby and ignore states wait for the next start.
        rsp_pkg::RSP_IDLE, rsp_pkg::RSP_WSTOP, rsp_pkg::RSP_IGNORE:
        begin
        end
        // Receiving one of the three bytes the controller sends.
        rsp_pkg::RSP_ID, rsp_pkg::RSP_WORD, rsp_pkg::RSP_WDATA:
        begin
          if (scl_rise)
          begin
            // Shift in at the rising clock, first bit into the top.
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            full_q    <= (bit_cnt_q == rsp_pkg::BIT_LAST);
          end
          else if (scl_fall && full_q)
          begin
            full_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
            if (state_q == rsp_pkg::RSP_ID)
            begin
              if (rx_q[7:1] == TARGET_ID)
              begin
                // Matching identifier: acknowledge and note the direction.
                sda_oe_q <= 1'b1;
                dir_q    <= rx_q[0];
                state_q  <= rsp_pkg::RSP_ACK_ID;
              end
              else
              begin
                // Someone else's frame: stay off the line until a start.
                state_q <= rsp_pkg::RSP_IGNORE;
              end
            end
            else if (state_q == rsp_pkg::RSP_WORD)
            begin
              // The single word-address byte sets the pointer.
              ptr_q    <= rx_q;
              sda_oe_q <= 1'b1;
              state_q  <= rsp_pkg::RSP_ACK_WORD;
            end
            else
            begin
              // The data byte is stored through wr_en in this same cycle.
              sda_oe_q <= 1'b1;
              state_q  <= rsp_pkg::RSP_ACK_DATA;
            end
          end
        end
        // End of the identifier acknowledge: read data or wait for an address.
        rsp_pkg::RSP_ACK_ID:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 3'h0;
            if (dir_q)
            begin
              // Current address read starts at the pointer.
              tx_q     <= {rd_data[6:0], 1'b0};
              sda_oe_q <= ~rd_data[7];
              ptr_q    <= next_ptr(ptr_q);
              state_q  <= rsp_pkg::RSP_TX;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              state_q  <= rsp_pkg::RSP_WORD;
            end
          end
        end
        // Release after the address acknowledge and take the data byte.
        rsp_pkg::RSP_ACK_WORD:
        begin
          if (scl_fall)
          begin
            sda_oe_q <= 1'b0;
            state_q  <= rsp_pkg::RSP_WDATA;
          end
        end
        // After the data acknowledge further bytes are not accepted.
        rsp_pkg::RSP_ACK_DATA:
        begin
          if (scl_fall)
          begin
            sda_oe_q <= 1'b0;
            state_q  <= rsp_pkg::RSP_WSTOP;
          end
        end
        // Sending a byte: change data only on the falling clock.
        rsp_pkg::RSP_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == rsp_pkg::BIT_LAST)
            begin
              // Eight bits out: hand the line to the controller.
              sda_oe_q <= 1'b0;
              more_q   <= 1'b0;
              state_q  <= rsp_pkg::RSP_TX_ACK;
            end
            else
            begin
              sda_oe_q  <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            end
          end
        end
        // Ninth clock of a sent byte: the controller's answer decides.
        rsp_pkg::RSP_TX_ACK:
        begin
          if (scl_rise)
            more_q <= ~sda_s;
          else if (scl_fall)
          begin
            bit_cnt_q <= 3'h0;
            if (more_q)
            begin
              tx_q     <= {rd_data[6:0], 1'b0};
              sda_oe_q <= ~rd_data[7];
              ptr_q    <= next_ptr(ptr_q);
              state_q  <= rsp_pkg::RSP_TX;
            end
            else
              state_q <= rsp_pkg::RSP_IGNORE;
          end
        end
      endcase
    end
  end

  // Open-drain output: the driven level is always low.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sda_out_q <= 1'b0;
    else
      sda_out_q <= 1'b0;
  end

  assign sda_out = sda_out_q;
  assign sda_oe  = sda_oe_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_quiet_busy;
    busy_q |-> !sda_oe && state_q == rsp_pkg::RSP_IDLE;
  endproperty
  a_quiet_busy : assert property (p_quiet_busy)
    else $error("Port left standby during power-up.");

  property p_busy_start;
    busy_q && start_det |=> state_q == rsp_pkg::RSP_IDLE;
  endproperty
  a_busy_start : assert property (p_busy_start)
    else $error("Start accepted during power-up.");

  property p_start_id;
    !busy_q && start_det && !stop_det |=> state_q == rsp_pkg::RSP_ID && bit_cnt_q == 3'h0;
  endproperty
  a_start_id : assert property (p_start_id)
    else $error("Start did not open identifier reception.");

  property p_stop_idle;
    stop_det |=> state_q == rsp_pkg::RSP_IDLE && !sda_oe;
  endproperty
  a_stop_idle : assert property (p_stop_idle)
    else $error("Stop did not return the port to standby.");

  property p_id_ack;
    state_q == rsp_pkg::RSP_ID && scl_fall && full_q && !bus_ev && rx_q[7:1] == TARGET_ID
    |=> sda_oe && state_q == rsp_pkg::RSP_ACK_ID;
  endproperty
  a_id_ack : assert property (p_id_ack)
    else $error("Matching identifier not acknowledged.");

  property p_id_nack;
    state_q == rsp_pkg::RSP_ID && scl_fall && full_q && !bus_ev && rx_q[7:1] != TARGET_ID
    |=> !sda_oe && state_q == rsp_pkg::RSP_IGNORE;
  endproperty
  a_id_nack : assert property (p_id_nack)
    else $error("Foreign identifier was answered.");

  property p_first_bit;
    load |=> sda_oe == !$past(rd_data[7]) && state_q == rsp_pkg::RSP_TX;
  endproperty
  a_first_bit : assert property (p_first_bit)
    else $error("Sent byte did not start with its top bit.");

  property p_release;
    state_q == rsp_pkg::RSP_TX && scl_fall && !bus_ev && bit_cnt_q == rsp_pkg::BIT_LAST
    |=> !sda_oe && state_q == rsp_pkg::RSP_TX_ACK;
  endproperty
  a_release : assert property (p_release)
    else $error("Line not released after eight sent bits.");

  property p_wrap;
    load && ptr_q == rsp_pkg::REG_LAST |=> ptr_q == rsp_pkg::REG_RESET;
  endproperty
  a_wrap : assert property (p_wrap)
    else $error("Pointer did not wrap after the last register.");

  property p_step;
    load && ptr_q < rsp_pkg::REG_LAST |=> ptr_q == 8'($past(ptr_q) + 8'h01);
  endproperty
  a_step : assert property (p_step)
    else $error("Pointer did not advance by one.");

  property p_one_write;
    wr_en |=> state_q == rsp_pkg::RSP_ACK_DATA ##1 !wr_en;
  endproperty
  a_one_write : assert property (p_one_write)
    else $error("More than one data byte written in a frame.");

  c_write : cover property (wr_en);
  c_read : cover property (load && state_q == rsp_pkg::RSP_TX_ACK);
  c_wrap : cover property (load && ptr_q == rsp_pkg::REG_LAST);
  c_nack : cover property (state_q == rsp_pkg::RSP_ID ##1 state_q == rsp_pkg::RSP_IGNORE);

endmodule

/* File: rtl/rsp_pkg.sv */
package rsp_pkg;

  // Width of a serial byte and of a register address.
  localparam int BYTE_W = 8;
  // Width of the target identifier carried in the first byte.
  localparam int ID_W = 7;
  // Highest implemented register address; the pointer wraps after it.
  localparam logic [7:0] REG_LAST = 8'h19;
  // Number of implemented registers, addresses 00h up to REG_LAST.
  localparam int NUM_REGS = 26;
  // First and last address of the battery-backed user storage.
  localparam logic [7:0] USER_FIRST = 8'h12;
  localparam logic [7:0] USER_LAST = 8'h19;
  // Address of the status register holding the alarm flag and auto-clear control.
  localparam logic [7:0] STATUS_ADDR = 8'h07;
  // Bit of the status register that enables auto clear on read.
  localparam int AUTO_CLEAR_BIT = 7;
  // Bit of the status register that holds the alarm flag.
  localparam int ALARM_BIT = 2;
  // Reset value of every register byte and of the pointer.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Index of the last bit within a byte, counted from zero.
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Length of the power-up sequence in clock cycles.
  localparam int PWRUP_CYCLES = 16;

  // Protocol sequencer states.
  typedef enum logic [3:0] {
    RSP_IDLE,
    RSP_ID,
    RSP_ACK_ID,
    RSP_WORD,
    RSP_ACK_WORD,
    RSP_WDATA,
    RSP_ACK_DATA,
    RSP_WSTOP,
    RSP_TX,
    RSP_TX_ACK,
    RSP_IGNORE
  } rsp_state_e;

endpackage

/* File: rtl/rsp_line_sync.sv */
`timescale 1ns/10ps
// Brings the two bus lines into the clock domain and finds their events.
module rsp_line_sync
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  logic scl_m_q;  // First synchroniser stage, read only by the second.
  logic sda_m_q;  // First synchroniser stage, read only by the second.
  logic scl_s_q;  // Second stage, safe to use.
  logic sda_s_q;  // Second stage, safe to use.
  logic scl_p_q;  // Previous value of the safe clock line.
  logic sda_p_q;  // Previous value of the safe data line.

  // Idle bus lines are high, so every stage resets high to avoid a false edge.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_in;
      sda_m_q <= sda_in;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_s    = scl_s_q;
  assign sda_s    = sda_s_q;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // A data edge counts as start or stop only while the clock stays high.
  assign start_det = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  assign stop_det  = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

endmodule

/* File: rtl/rsp_reg_array.sv */
`timescale 1ns/10ps
// Byte-wide register array reached by the serial port.
module rsp_reg_array #(
  parameter int NUM_REGS = rsp_pkg::NUM_REGS
)
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       alarm_set,
  output logic            alarm_flag
);

  logic [7:0] regs_q [NUM_REGS];  // Register storage, one byte per address.

  // True when an address falls inside the implemented range.
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a < 8'(NUM_REGS));
  endfunction

  // Each byte is its own flop group; the status byte adds the alarm handling.
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_byte
    if (g == int'(rsp_pkg::STATUS_ADDR))
    begin : g_status
      // Hardware setting the alarm wins over a clear by write or by read.
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          regs_q[g] <= rsp_pkg::REG_RESET;
        else
        begin
          if (wr_en && wr_addr == 8'(g))
            regs_q[g] <= wr_data;
          if (rd_en && rd_addr == 8'(g) && regs_q[g][rsp_pkg::AUTO_CLEAR_BIT])
            regs_q[g][rsp_pkg::ALARM_BIT] <= 1'b0;
          if (alarm_set)
            regs_q[g][rsp_pkg::ALARM_BIT] <= 1'b1;
        end
      end
    end
    else
    begin : g_plain
      // Plain storage byte, including the user storage at the top.
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          regs_q[g] <= rsp_pkg::REG_RESET;
        else if (wr_en && wr_addr == 8'(g))
          regs_q[g] <= wr_data;
      end
    end
  end

  // Unimplemented addresses read as zero and swallow writes.
  assign rd_data    = addr_ok(rd_addr) ? regs_q[rd_addr[4:0]] : 8'h00;
  assign alarm_flag = regs_q[rsp_pkg::STATUS_ADDR[4:0]][rsp_pkg::ALARM_BIT];

  property p_user_store;
    @(posedge clk) disable iff (!rst_b)
    wr_en && wr_addr >= rsp_pkg::USER_FIRST && wr_addr <= rsp_pkg::USER_LAST
    |=> regs_q[$past(wr_addr[4:0])] == $past(wr_data);
  endproperty
  a_user_store : assert property (p_user_store)
    else $error("User storage byte did not take the written value.");

  property p_auto_clear;
    @(posedge clk) disable iff (!rst_b)
    rd_en && rd_addr == rsp_pkg::STATUS_ADDR && rd_data[rsp_pkg::AUTO_CLEAR_BIT] && !alarm_set
    |=> !alarm_flag;
  endproperty
  a_auto_clear : assert property (p_auto_clear)
    else $error("Status read with auto clear left the alarm flag set.");

endmodule

/* File: dv/rsp_ctrl_model.sv */
`timescale 1ns/10ps
// Behavioural bus controller: makes the link clock and drives data, open drain.
module rsp_ctrl_model
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_o,
  output logic      sda_o
);
  // Both lines rest high between frames, as the pull-ups leave them.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Five system clocks make a quarter of the 80 ns link period.
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while the link clock is low.
  task automatic bit_w(input logic b);
    sda_o <= b;
    hc(5);
    scl_o <= 1'b1;
    hc(10);
    scl_o <= 1'b0;
    hc(5);
  endtask
  // Releases data and samples it mid-way through the high half.
  task automatic bit_r(output logic b);
    sda_o <= 1'b1;
    hc(5);
    scl_o <= 1'b1;
    hc(5);
    b = sda_line;
    hc(5);
    scl_o <= 1'b0;
    hc(5);
  endtask
  // Also serves as a repeated start, since it raises data before the clock.
  task automatic start();
    sda_o <= 1'b1;
    hc(5);
    scl_o <= 1'b1;
    hc(5);
    sda_o <= 1'b0;
    hc(5);
    scl_o <= 1'b0;
    hc(5);
  endtask
  // Ends the frame with data rising while the clock is high.
  task automatic stop();
    sda_o <= 1'b0;
    hc(5);
    scl_o <= 1'b1;
    hc(5);
    sda_o <= 1'b1;
    hc(5);
  endtask
  // Sends a byte highest bit first, then releases for the acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_w(d[i]);
    bit_r(a);
    ack = ~a;
  endtask
  // Takes a byte and acknowledges it unless it is the last one wanted.
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_r(b);
      d[i] = b;
    end
    bit_w(~more);
  endtask
endmodule

/* File: dv/tb_rtc_serial_register_port.sv */
`timescale 1ns/10ps
// Bench for the serial port, checked against an array model of the registers.
module tb_rtc_serial_register_port;
  localparam logic [6:0] TB_ID = 7'h35;  // Arbitrary identifier value.
  logic       clk;
  logic       rst_b;
  logic       alarm_event;
  logic       sda_out;
  logic       sda_oe;
  logic       alarm_flag;
  logic       scl;
  logic       sda_m;
  logic [7:0] mem [0:25];  // Expected register contents.
  logic       alarm_exp;   // Expected alarm flag.
  int         ptr;
  int         bad_count;
  int         cmp_count;
  wire logic  sda_line;
  // The line is low when either party pulls it, else the pull-up wins.
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);
  rsp_serial_port #(.TARGET_ID(TB_ID), .PWRUP_CYCLES(40)) dut_u (.clk(clk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda_line), .alarm_event(alarm_event), .sda_out(sda_out),
    .sda_oe(sda_oe), .alarm_flag(alarm_flag));
  rsp_ctrl_model ctl_u (.clk(clk), .sda_line(sda_line), .scl_o(scl), .sda_o(sda_m));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Sends one byte and compares the acknowledge with the expected one.
  task automatic sb(input logic [7:0] d, input logic e);
    logic a;
    ctl_u.wbyte(d, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  // Status reads show the alarm flag in bit 2; unimplemented places read zero.
  function automatic logic [7:0] rdv(input int p);
    if (p == 7)
      return {mem[7][7:3], alarm_exp, mem[7][1:0]};
    return (p < 26) ? mem[p] : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int extra);
    ctl_u.start();
    sb({TB_ID, 1'b0}, 1'b1);
    sb(a, 1'b1);
    sb(d, 1'b1);
    for (int i = 0; i < extra; i++)
      sb(~d, 1'b0);
    ctl_u.stop();
    if (a < 8'h1a)
      mem[a] = d;
    if (a == 8'h07)
      alarm_exp = d[2];
    ptr = a;
  endtask
  // A negative address asks for a read from the current pointer.
  task automatic rd(input int a, input int n);
    logic [7:0] d;
    ctl_u.start();
    if (a >= 0)
    begin
      sb({TB_ID, 1'b0}, 1'b1);
      sb(a[7:0], 1'b1);
      ctl_u.start();
      ptr = a;
    end
    sb({TB_ID, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      ctl_u.rbyte(i < n - 1, d);
      chk(d, rdv(ptr));
      if (ptr == 7 && mem[7][7])
        alarm_exp = 1'b0;
      ptr = (ptr >= 25) ? 0 : ptr + 1;
    end
    ctl_u.stop();
  endtask
  // Bounds the whole run so a hung handshake still reaches the verdict.
  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("timeout");
    final_report();
  end
  initial
  begin
    rst_b = 1'b0;
    alarm_event = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    alarm_exp = 1'b0;
    ptr = 0;
    for (int i = 0; i < 26; i++)
      mem[i] = 8'h00;
    void'($urandom(39027));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // A frame begun inside the power-up sequence gets no answer.
    ctl_u.start();
    sb({TB_ID, 1'b0}, 1'b0);
    ctl_u.stop();
    chk({7'h00, sda_oe}, 8'h00);
    $display("test power_up done");
    rd(-1, 3);
    $display("test current_read done");
    for (int a = 8'h12; a <= 8'h19; a++)
      wr(a[7:0], 8'($urandom), 0);
    rd(8'h12, 10);
    $display("test user_storage done");
    // Any single wrong identifier bit must be refused, with the frame ignored.
    for (int b = 0; b < 7; b++)
    begin
      ctl_u.start();
      sb({TB_ID ^ (7'h01 << b), 1'b0}, 1'b0);
      sb(8'h12, 1'b0);
      ctl_u.stop();
    end
    // Refused frames must leave the pointer where the last read put it.
    rd(-1, 1);
    rd(8'h12, 1);
    $display("test wrong_id done");
    wr(8'h13, 8'($urandom), 1);
    wr(8'h1f, 8'($urandom), 0);
    rd(8'h1f, 2);
    rd(8'h13, 1);
    $display("test write_limits done");
    // The flag survives a status read unless auto clear is set.
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h07, (m == 0) ? 8'h80 : 8'h00, 0);
      @(posedge clk);
      alarm_event <= 1'b1;
      @(posedge clk);
      alarm_event <= 1'b0;
      alarm_exp = 1'b1;
      repeat (3) @(posedge clk);
      chk({7'h00, alarm_flag}, 8'h01);
      rd(8'h07, 1);
      @(negedge clk);
      chk({7'h00, alarm_flag}, {7'h00, alarm_exp});
    end
    $display("test alarm_clear done");
    final_report();
  end
endmodule
